// [hdl/msr_pkg.sv]
// constants for the multi-speed run select block
// assumes a 100 MHz pclk and an APB register window of 4 KB
package msr_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned RAMP_UNIT_MS = 100;
  localparam int unsigned RATED_RPM = 4000;
  localparam int unsigned RAMP_TICK_CYC = (CLK_HZ / 1000 * RAMP_UNIT_MS) / RATED_RPM;
  localparam logic [11:0] RAMP_TICK_LAST = 12'(RAMP_TICK_CYC - 1);
  localparam logic [15:0] SPEED_MAX = 16'(RATED_RPM);

  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_LIMIT = 12'h004;
  localparam logic [11:0] REG_IOMAP = 12'h008;
  localparam logic [11:0] REG_STATUS = 12'h00C;
  localparam logic [11:0] REG_SPEED = 12'h010;
  localparam logic [11:0] REG_DATA0 = 12'h020;

  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_LOCK_BIT = 2;
  localparam int CTRL_TSRC_BIT = 3;
  localparam int CTRL_INITD_BIT = 4;
  localparam int CTRL_INITP_BIT = 5;
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam int LIM_HI_LSB = 0;
  localparam int LIM_LO_LSB = 16;
  localparam logic [31:0] LIMIT_RST = 32'h0000_0FA0;
  localparam int OMAP_LSB = 16;
  localparam logic [19:0] IOMAP_RST = 20'h4_4688;

  localparam int DATA_SPD_LSB = 0;
  localparam int DATA_ACC_LSB = 16;
  localparam int DATA_DEC_LSB = 24;
  localparam logic [31:0] DATA_RST = 32'h0505_0032;

  localparam int STAT_NO_LSB = 0;
  localparam int STAT_RUN_BIT = 2;
  localparam int STAT_DIR_BIT = 3;
  localparam int STAT_LOAD_LSB = 8;
  localparam int STAT_STATE_LSB = 16;

  localparam logic FORWARD_SENSE = 1'b0;
  localparam int LOAD_SHIFT = 12;
  localparam logic [6:0] LOAD_SCALE = 7'h64;

  typedef enum logic [1:0] {
    MODE_PANEL = 2'h0,
    MODE_EXT_PANEL = 2'h1,
    MODE_EXT_ONLY = 2'h2
  } msr_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN = 3'b010,
    ST_TURN = 3'b100
  } msr_state_t;
endpackage : msr_pkg

// [hdl/msr_sync.sv]
// two-flop synchroniser for a group of pin inputs
// assumes each bit is an independent level from outside the pclk domain
`timescale 1ns/1ns
module msr_sync
  import msr_pkg::*;
#(
  parameter int W = 9
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_r <= '0;
      q_r <= '0;
    end
    else
    begin
      meta_r <= d;
      q_r <= meta_r;
    end
  end

  assign q = q_r;
endmodule : msr_sync

// [hdl/msr_data_mem.sv]
// operation data store: one word per entry, two registered read ports
// assumes a single writer per cycle; init has priority over writes
`timescale 1ns/1ns
module msr_data_mem
  import msr_pkg::*;
#(
  parameter int N = 4,
  parameter int AW = 2
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic init,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [31:0] wr_data,
  input wire logic bump_up,
  input wire logic bump_dn,
  input wire logic [AW-1:0] rd_addr_a,
  output logic [31:0] rd_data_a,
  input wire logic [AW-1:0] rd_addr_b,
  output logic [31:0] rd_data_b
);
  logic [31:0] mem_r [N];
  logic [31:0] rda_r;
  logic [31:0] rdb_r;
  logic [15:0] spd0;

  assign spd0 = mem_r[0][DATA_SPD_LSB +: 16];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < N; i++)
        mem_r[i] <= DATA_RST;
      rda_r <= '0;
      rdb_r <= '0;
    end
    else
    begin
      rda_r <= mem_r[rd_addr_a];
      rdb_r <= mem_r[rd_addr_b];
      if (init)
      begin
        for (int i = 0; i < N; i++)
          mem_r[i] <= DATA_RST;
      end
      else if (wr_en)
        mem_r[wr_addr] <= wr_data;
      else if (bump_up && spd0 < SPEED_MAX)
        mem_r[0][DATA_SPD_LSB +: 16] <= spd0 + 16'h0001;
      else if (bump_dn && spd0 != 16'h0000)
        mem_r[0][DATA_SPD_LSB +: 16] <= spd0 - 16'h0001;
    end
  end

  assign rd_data_a = rda_r;
  assign rd_data_b = rdb_r;
endmodule : msr_data_mem

// [hdl/msr_run_ctrl.sv]
// run control of a brushless motor driver: entry select, ramp, direction,
// APB registers. assumes pins are asynchronous levels, time_pot and
// load_raw come from converters already on pclk.
`timescale 1ns/1ns
// Notes on behaviour
// - two select inputs pick entry 0..3 as a binary number, bit0 low.
// - running uses speed, acceleration and deceleration of selected entry.
// - by default ramp times come from the analog time potentiometer.
// - entry change ramps to new speed with new entry's ramp times.
// - forward or reverse run input starts rotation at selected speed.
// - dropping the asserted run input decelerates the motor to stop.
// - rotation sense follows the panel direction switch.
// - direction change while running: decelerate to zero, then reverse.
// - external-only mode ignores the direction switch.
// - external-only mode: forward input rotates in the forward switch sense, reverse input the other way.
// - at most four selectable speed entries.
// - lock rejects setting dial operations on stored data.
// - five input and two output functions are remappable.
// - commanded speed clamped between upper and lower limits.
// - command restores all operation data entries to defaults.
// - command restores all parameter settings to defaults.
// - number of entry in use is available for display.
// - load torque reported as a percentage.
// - both run inputs asserted stops the motor instantly.
// - mode selects panel only, external plus panel, or external only.
// - panel switch to standby decelerates to stop despite run input.
module msr_run_ctrl
  import msr_pkg::*;
#(
  parameter int N_ENTRY = 4,
  parameter int N_IN = 5
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [N_IN-1:0] ext_in,
  input wire logic panel_run_sw,
  input wire logic panel_dir_sw,
  input wire logic dial_up,
  input wire logic dial_dn,
  input wire logic [7:0] time_pot,
  input wire logic [11:0] load_raw,
  output logic [1:0] ext_out,
  output logic [15:0] speed_cmd,
  output logic motor_dir,
  output logic [1:0] data_no,
  output logic [6:0] load_pct
);
  localparam int SW = N_IN + 4;
  logic [SW-1:0] pin_s;
  logic [N_IN-1:0] in_s;
  logic run_sw_s;
  logic dir_sw_s;
  logic dial_up_s;
  logic dial_dn_s;

  msr_sync #(.W(SW)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({dial_dn, dial_up, panel_dir_sw, panel_run_sw, ext_in}),
    .q(pin_s)
  );
  assign in_s = pin_s[N_IN-1:0];
  assign run_sw_s = pin_s[N_IN];
  assign dir_sw_s = pin_s[N_IN+1];
  assign dial_up_s = pin_s[N_IN+2];
  assign dial_dn_s = pin_s[N_IN+3];

  // registers
  logic [3:0] ctrl_r;
  logic [31:0] limit_r;
  logic [19:0] iomap_r;
  logic init_data_r;
  logic init_par_r;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  msr_mode_t mode;
  assign mode = msr_mode_t'(ctrl_r[CTRL_MODE_LSB +: 2]);

  // input remap: each function picks a pin, codes 5..7 read as off
  logic [7:0] in_pad;
  logic [N_IN-1:0] func;
  assign in_pad = 8'(in_s);
  genvar g;
  generate
    for (g = 0; g < N_IN; g++)
    begin : g_imap
      assign func[g] = in_pad[iomap_r[3*g +: 3]];
    end
  endgenerate

  logic forward_run_input;
  logic reverse_run_input;
  logic speed_select_bit0;
  logic speed_select_bit1;
  logic halt_input;
  logic external_only_mode;
  assign forward_run_input = func[0];
  assign reverse_run_input = func[1];
  assign speed_select_bit0 = func[2];
  assign speed_select_bit1 = func[3];
  assign halt_input = func[4];
  assign external_only_mode = (mode == MODE_EXT_ONLY);

  logic [1:0] sel_no;
  assign sel_no = {speed_select_bit1, speed_select_bit0};

  // run request and direction
  logic ext_cmd;
  logic quick_stop;
  logic run_req;
  logic dir_want;
  assign ext_cmd = forward_run_input ^ reverse_run_input;
  assign quick_stop = (mode != MODE_PANEL) && forward_run_input
    && reverse_run_input;
  assign run_req = ~halt_input & (
    (mode == MODE_PANEL) ? run_sw_s :
    (mode == MODE_EXT_PANEL) ? (run_sw_s & ext_cmd) :
    external_only_mode & ext_cmd);
  assign dir_want = external_only_mode ? (FORWARD_SENSE ^ reverse_run_input)
    : (dir_sw_s ^ ((mode != MODE_PANEL) & reverse_run_input));

  // operation data
  logic [31:0] entry;
  logic [31:0] apb_entry;
  logic apb_wr;
  logic dial_ok;
  logic up_d_r;
  logic dn_d_r;
  logic hit_data;

  msr_data_mem #(.N(N_ENTRY), .AW(2)) u_mem (
    .pclk(pclk),
    .presetn(presetn),
    .init(init_data_r),
    .wr_en(apb_wr & hit_data),
    .wr_addr(paddr[3:2]),
    .wr_data(pwdata),
    .bump_up(dial_ok & dial_up_s & ~up_d_r),
    .bump_dn(dial_ok & dial_dn_s & ~dn_d_r),
    .rd_addr_a(sel_no),
    .rd_data_a(entry),
    .rd_addr_b(paddr[3:2]),
    .rd_data_b(apb_entry)
  );
  assign dial_ok = ~ctrl_r[CTRL_LOCK_BIT] & ~external_only_mode;

  // target speed with limits
  logic [15:0] ent_spd;
  logic [15:0] lim_hi;
  logic [15:0] lim_lo;
  logic [15:0] spd_clamped;
  assign ent_spd = entry[DATA_SPD_LSB +: 16];
  assign lim_hi = limit_r[LIM_HI_LSB +: 16];
  assign lim_lo = limit_r[LIM_LO_LSB +: 16];
  assign spd_clamped = (ent_spd > lim_hi) ? lim_hi :
    (ent_spd < lim_lo) ? lim_lo : ent_spd;

  msr_state_t state_r;
  msr_state_t state_nxt;
  logic [15:0] speed_r;
  logic dir_r;
  logic [15:0] target;
  logic spd_zero;
  assign spd_zero = (speed_r == 16'h0000);
  assign target = (state_r == ST_RUN) ? spd_clamped : 16'h0000;

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:
        if (run_req && (spd_zero || dir_want == dir_r))
          state_nxt = ST_RUN;
      ST_RUN:
        if (!run_req)
          state_nxt = ST_IDLE;
        else if (dir_want != dir_r)
          state_nxt = ST_TURN;
      ST_TURN:
        if (spd_zero)
          state_nxt = run_req ? ST_RUN : ST_IDLE;
      default:
        state_nxt = ST_IDLE;
    endcase
    if (quick_stop)
      state_nxt = ST_IDLE;
  end

  // ramp: tick every RAMP_TICK_CYC, one r/min step every (time+1) ticks
  logic [11:0] tick_r;
  logic [7:0] step_r;
  logic tick;
  logic accel;
  logic [7:0] cur_time;
  logic step_due;
  assign tick = (tick_r == RAMP_TICK_LAST);
  assign accel = (speed_r < target);
  assign cur_time = !ctrl_r[CTRL_TSRC_BIT] ? time_pot :
    accel ? entry[DATA_ACC_LSB +: 8] : entry[DATA_DEC_LSB +: 8];
  assign step_due = tick && (step_r >= cur_time);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r <= ST_IDLE;
      dir_r <= FORWARD_SENSE;
      speed_r <= '0;
      tick_r <= '0;
      step_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      if (state_r != ST_RUN && state_nxt == ST_RUN && spd_zero)
        dir_r <= dir_want;
      tick_r <= tick ? 12'h000 : tick_r + 12'h001;
      if (tick)
        step_r <= step_due ? 8'h00 : step_r + 8'h01;
      if (quick_stop)
        speed_r <= '0;
      else if (step_due && accel)
        speed_r <= speed_r + 16'h0001;
      else if (step_due && speed_r > target)
        speed_r <= speed_r - 16'h0001;
    end
  end

  // display and pin outputs
  logic [18:0] load_prod;
  logic [1:0] ext_out_r;
  logic [1:0] data_no_r;
  logic [6:0] load_pct_r;
  logic [3:0] ofunc;
  assign load_prod = 19'(load_raw) * 19'(LOAD_SCALE);
  assign ofunc = {spd_zero, dir_r, (state_r == ST_RUN) && (speed_r == target),
    ~spd_zero | (state_r != ST_IDLE)};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ext_out_r <= '0;
      data_no_r <= '0;
      load_pct_r <= '0;
      up_d_r <= 1'b0;
      dn_d_r <= 1'b0;
    end
    else
    begin
      ext_out_r[0] <= ofunc[iomap_r[OMAP_LSB +: 2]];
      ext_out_r[1] <= ofunc[iomap_r[OMAP_LSB + 2 +: 2]];
      data_no_r <= sel_no;
      load_pct_r <= load_prod[LOAD_SHIFT +: 7];
      up_d_r <= dial_up_s;
      dn_d_r <= dial_dn_s;
    end
  end

  // APB slave: one wait state, read data registered on the edge that raises pready, write on the edge that ends the pready cycle
  logic hit_ctrl;
  logic hit_limit;
  logic hit_iomap;
  logic hit_status;
  logic hit_speed;
  logic mapped;
  logic [31:0] rd_mux;
  logic [31:0] status_word;
  assign hit_ctrl = (paddr == REG_CTRL);
  assign hit_limit = (paddr == REG_LIMIT);
  assign hit_iomap = (paddr == REG_IOMAP);
  assign hit_status = (paddr == REG_STATUS);
  assign hit_speed = (paddr == REG_SPEED);
  assign hit_data = (paddr[11:4] == REG_DATA0[11:4]) && (paddr[1:0] == 2'h0);
  assign mapped = hit_ctrl | hit_limit | hit_iomap | hit_status | hit_speed | hit_data;
  assign apb_wr = psel & penable & pwrite & pready_r & mapped;
  assign status_word = (32'(data_no_r) << STAT_NO_LSB)
    | (32'(state_r != ST_IDLE) << STAT_RUN_BIT)
    | (32'(dir_r) << STAT_DIR_BIT)
    | (32'(load_pct_r) << STAT_LOAD_LSB)
    | (32'(state_r) << STAT_STATE_LSB);
  assign rd_mux = hit_ctrl ? 32'(ctrl_r) :
    hit_limit ? limit_r :
    hit_iomap ? 32'(iomap_r) :
    hit_status ? status_word :
    hit_speed ? 32'(speed_r) :
    hit_data ? apb_entry : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= '0;
      ctrl_r <= CTRL_RST;
      limit_r <= LIMIT_RST;
      iomap_r <= IOMAP_RST;
      init_data_r <= 1'b0;
      init_par_r <= 1'b0;
    end
    else
    begin
      pready_r <= psel & penable & ~pready_r;
      pslverr_r <= psel & penable & ~pready_r & ~mapped;
      if (psel && penable && !pready_r && !pwrite)
        prdata_r <= rd_mux;
      init_data_r <= apb_wr & hit_ctrl & pwdata[CTRL_INITD_BIT];
      init_par_r <= apb_wr & hit_ctrl & pwdata[CTRL_INITP_BIT];
      if (init_par_r)
      begin
        ctrl_r <= CTRL_RST;
        limit_r <= LIMIT_RST;
        iomap_r <= IOMAP_RST;
      end
      else if (apb_wr)
      begin
        if (hit_ctrl)
          ctrl_r <= pwdata[3:0];
        if (hit_limit)
          limit_r <= pwdata;
        if (hit_iomap)
          iomap_r <= pwdata[19:0];
      end
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign ext_out = ext_out_r;
  assign speed_cmd = speed_r;
  assign motor_dir = dir_r;
  assign data_no = data_no_r;
  assign load_pct = load_pct_r;
endmodule : msr_run_ctrl

// [verif/msr_run_ctrl_properties.sv]
// checker for the run select block: bus timing, ramp, stop and display relations
// assumes the default pin map: forward, reverse, select bits 0 and 1 on pins 0 to 3
`timescale 1ns/1ns
module msr_run_ctrl_properties
  import msr_pkg::*;
#(
  parameter int N_IN = 5
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [N_IN-1:0] ext_in,
  input wire logic [11:0] load_raw,
  input wire logic [15:0] speed_cmd,
  input wire logic motor_dir,
  input wire logic [1:0] data_no,
  input wire logic [6:0] load_pct
);
  logic [15:0] spd_q_r;
  logic [11:0] gap_r;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // cycles since the commanded speed last moved, saturating
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      spd_q_r <= 16'h0000;
      gap_r <= 12'h000;
    end
    else
    begin
      spd_q_r <= speed_cmd;
      gap_r <= (speed_cmd != spd_q_r) ? 12'h000 : gap_r + {11'h000, gap_r != 12'hFFF};
    end
  end
  apb_wait_state_a: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("ready not in second access cycle");
  ready_one_cycle_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  entry_number_a: assert property (($stable(ext_in[3:2]))[*4] |-> data_no == ext_in[3:2])
    else $error("entry number does not follow select pins");
  both_run_stop_a: assert property ((ext_in[1:0] == 2'h3)[*4] |-> speed_cmd == 16'h0000)
    else $error("both run pins did not stop at once");
  stop_on_release_a: assert property ((ext_in[1:0] == 2'h0)[*4] |-> speed_cmd <= $past(speed_cmd))
    else $error("speed rose with no run pin");
  ramp_step_a: assert property ($changed(speed_cmd) && speed_cmd != 16'h0000 |->
    speed_cmd == $past(speed_cmd) + 16'h0001 || speed_cmd == $past(speed_cmd) - 16'h0001)
    else $error("speed jumped");
  ramp_spacing_a: assert property ($changed(speed_cmd) && speed_cmd != 16'h0000 &&
    $past(speed_cmd) != 16'h0000 |-> gap_r >= RAMP_TICK_LAST)
    else $error("ramp step faster than one tick");
  turn_at_rest_a: assert property ($changed(motor_dir) |->
    speed_cmd == 16'h0000 || $past(speed_cmd) == 16'h0000)
    else $error("direction changed while moving");
  load_percent_a: assert property (($stable(load_raw))[*4] |->
    load_pct == 7'((20'(load_raw) * 20'h00064) >> 12))
    else $error("load percent wrong");
  cover property (pslverr);
  cover property ($fell(motor_dir));
  cover property ((ext_in[1:0] == 2'h3)[*4] ##1 speed_cmd == 16'h0000);
endmodule : msr_run_ctrl_properties

bind msr_run_ctrl msr_run_ctrl_properties #(.N_IN(N_IN)) i_props (.pclk, .presetn, .psel,
  .penable, .pready, .pslverr, .ext_in, .load_raw, .speed_cmd, .motor_dir, .data_no, .load_pct);

// [verif/msr_ctrl_model.sv]
// partner model: an outside controller driving the run and select pins
// assumes the default pin map; pins change just after a rising edge
`timescale 1ns/1ns
module msr_ctrl_model
(
  input wire logic pclk,
  input wire logic forward_run_input,
  input wire logic reverse_run_input,
  input wire logic speed_select_bit0,
  input wire logic speed_select_bit1,
  output logic [4:0] pins
);
  // pin 4 carries the halt function, which this controller never uses
  always_ff @(posedge pclk)
  begin
    pins <= {1'b0, speed_select_bit1, speed_select_bit0, reverse_run_input, forward_run_input};
  end
endmodule : msr_ctrl_model

// [verif/multi_speed_run_select_tb.sv]
// testbench of the run select block: register access over apb and pin scenarios
// assumes the checker is bound to msr_run_ctrl and the controller model drives the pins
`timescale 1ns/1ns
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module multi_speed_run_select_tb
  import msr_pkg::*;
;
  int n_mismatch = 0;
  int checks = 0;
  int cyc = 0;
  int n;
  logic er, pclk, presetn, psel, penable, pwrite, pready, pslverr, motor_dir;
  logic panel_run_sw, panel_dir_sw, dial_up, dial_dn;
  logic forward_run_input, reverse_run_input, speed_select_bit0, speed_select_bit1;
  logic [11:0] paddr, load_raw;
  logic [31:0] rd, pwdata, prdata;
  logic [7:0] time_pot;
  logic [4:0] ext_in;
  logic [1:0] ext_out, data_no;
  logic [15:0] speed_cmd;
  logic [6:0] load_pct;
  logic [15:0] spd [4] = '{16'h0002, 16'h0001, 16'h0001, 16'h0004};

  msr_run_ctrl i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .ext_in, .panel_run_sw, .panel_dir_sw, .dial_up, .dial_dn, .time_pot,
    .load_raw, .ext_out, .speed_cmd, .motor_dir, .data_no, .load_pct);
  msr_ctrl_model i_ctrl (.pclk, .forward_run_input, .reverse_run_input, .speed_select_bit0,
    .speed_select_bit1, .pins(ext_in));

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic finish_test;
    if (n_mismatch == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : finish_test

  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 100000)
    begin
      n_mismatch++;
      finish_test();
    end
  end

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(nm, e, rd)
  endtask : rchk

  task automatic wspd(input logic [15:0] s);
    n = 0;
    while (speed_cmd !== s)
    begin
      @(posedge pclk);
      n++;
    end
  endtask : wspd

  task automatic dial(input logic up);
    dial_up <= up;
    dial_dn <= ~up;
    repeat (4) @(posedge pclk);
    dial_up <= 1'b0;
    dial_dn <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask : dial

  initial
  begin
    presetn <= 1'b0;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 12'h000;
    pwdata <= 32'h0000_0000;
    panel_run_sw <= 1'b0;
    panel_dir_sw <= 1'b0;
    dial_up <= 1'b0;
    dial_dn <= 1'b0;
    time_pot <= 8'h00;
    load_raw <= 12'h000;
    forward_run_input <= 1'b0;
    reverse_run_input <= 1'b0;
    speed_select_bit0 <= 1'b0;
    speed_select_bit1 <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rchk("ctrl", REG_CTRL, 32'h0000_0000);
    rchk("limit", REG_LIMIT, LIMIT_RST);
    rchk("iomap", REG_IOMAP, 32'(IOMAP_RST));
    for (int i = 0; i < 4; i++)
    begin
      rchk("entry", REG_DATA0 + 12'(4 * i), DATA_RST);
      apb(1'b1, REG_DATA0 + 12'(4 * i), 32'(spd[i]));
    end
    apb(1'b0, 12'h100, 32'h0000_0000);
    `CHK("slverr", 1'b1, er)
    `CHK("unmapped", 32'h0000_0000, rd)
    apb(1'b1, REG_CTRL, 32'h0000_0001);
    panel_run_sw <= 1'b1;
    forward_run_input <= 1'b1;
    wspd(16'h0002);
    `CHK("dir", FORWARD_SENSE, motor_dir)
    rchk("status", REG_STATUS, 32'h0002_0004);
    speed_select_bit0 <= 1'b1;
    wspd(16'h0001);
    `CHK("data_no", 2'h1, data_no)
    time_pot <= 8'h01;
    speed_select_bit1 <= 1'b1;
    wspd(16'h0004);
    `CHK("pot ramp", 1'b1, n > 9000)
    apb(1'b1, REG_CTRL, 32'h0000_0009);
    speed_select_bit0 <= 1'b0;
    wspd(16'h0001);
    `CHK("entry ramp", 1'b1, n < 9000)
    panel_dir_sw <= 1'b1;
    wspd(16'h0000);
    wspd(16'h0001);
    `CHK("turn", ~FORWARD_SENSE, motor_dir)
    panel_run_sw <= 1'b0;
    wspd(16'h0000);
    apb(1'b1, REG_CTRL, 32'h0000_000A);
    wspd(16'h0001);
    `CHK("ext dir", FORWARD_SENSE, motor_dir)
    forward_run_input <= 1'b0;
    wspd(16'h0000);
    apb(1'b1, REG_CTRL, 32'h0000_0009);
    panel_run_sw <= 1'b1;
    reverse_run_input <= 1'b1;
    wspd(16'h0001);
    `CHK("reverse dir", FORWARD_SENSE, motor_dir)
    forward_run_input <= 1'b1;
    repeat (5) @(posedge pclk);
    `CHK("both stop", 16'h0000, speed_cmd)
    forward_run_input <= 1'b0;
    reverse_run_input <= 1'b0;
    apb(1'b1, REG_LIMIT, 32'h0000_0003);
    speed_select_bit0 <= 1'b1;
    forward_run_input <= 1'b1;
    wspd(16'h0003);
    repeat (3000) @(posedge pclk);
    `CHK("clamp", 16'h0003, speed_cmd)
    `CHK("out run", 1'b1, ext_out[0])
    `CHK("out speed", 1'b1, ext_out[1])
    forward_run_input <= 1'b0;
    wspd(16'h0000);
    apb(1'b1, REG_IOMAP, 32'h0007_4688);
    repeat (3) @(posedge pclk);
    `CHK("out stop", 1'b1, ext_out[0])
    apb(1'b1, REG_CTRL, 32'h0000_0005);
    dial(1'b1);
    rchk("locked", REG_DATA0, 32'h0000_0002);
    apb(1'b1, REG_CTRL, 32'h0000_0001);
    dial(1'b1);
    rchk("dial", REG_DATA0, 32'h0000_0003);
    apb(1'b1, REG_CTRL, 32'h0000_0002);
    dial(1'b0);
    rchk("ext dial", REG_DATA0, 32'h0000_0003);
    apb(1'b1, REG_CTRL, 32'h0000_0001);
    dial(1'b0);
    rchk("dial down", REG_DATA0, 32'h0000_0002);
    panel_run_sw <= 1'b0;
    apb(1'b1, REG_CTRL, 32'h0000_0010);
    rchk("init data", REG_DATA0 + 12'h00C, DATA_RST);
    apb(1'b1, REG_CTRL, 32'h0000_0025);
    rchk("init ctrl", REG_CTRL, 32'h0000_0000);
    rchk("init limit", REG_LIMIT, LIMIT_RST);
    rchk("init iomap", REG_IOMAP, 32'(IOMAP_RST));
    load_raw <= 12'h800;
    repeat (6) @(posedge pclk);
    `CHK("load", 7'h32, load_pct)
    finish_test();
  end
endmodule : multi_speed_run_select_tb
